// ==== hdl/cel_loader.v ====
// Purpose: Calibration loader: fuse fill with ECC, EEPROM reload, software byte access
// Assumes: APB slave with no wait states; fuse array read combinationally;
//    EEPROM reached by a request/acknowledge byte port
// Notes: Shadow words are readable over APB at any time and writable only while the loader is idle
`timescale 1ns/1ps
`include "cel_regs.vh"
module cel_loader
(
   // APB clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // Fuse array
   output wire [2:0] fuse_addr,
   input wire [15:0] fuse_data,
   input wire [4:0] fuse_check,
   // EEPROM byte port
   input wire nvm_present,
   output reg nvm_req_q,
   output reg nvm_we_q,
   output reg [7:0] nvm_addr_q,
   output reg [7:0] nvm_wdata_q,
   input wire nvm_ack,
   input wire [7:0] nvm_rdata,
   // Die temperature
   input wire [7:0] die_temp,
   // Calibration outputs
   output reg cal_valid_q,
   output wire [15:0] first_cell_gain,
   output wire [15:0] third_cell_gain,
   output wire [9:0] odd_cell_room_gain_delta,
   output wire [3:0] first_pair_room_delta,
   output wire [1:0] second_pair_room_delta,
   output wire [6:0] odd_cell_cold_gain_delta,
   output wire [6:0] odd_cell_hot_gain_delta,
   output reg [15:0] diag_reference_gain_q
);

   // Loader states
   localparam ST_FUSE = 5'b00001;
   localparam ST_KEY = 5'b00010;
   localparam ST_LOAD = 5'b00100;
   localparam ST_IDLE = 5'b01000;
   localparam ST_CMD = 5'b10000;

   reg [4:0] state_q;
   reg [4:0] state_d;
   reg [2:0] word_q;
   reg [4:0] byte_q;
   reg [7:0] hi_byte_q;
   reg [15:0] shadow_q [0:`CEL_WORDS-1];
   reg [7:0] ctrl_addr_q;
   reg [7:0] nvm_write_byte_field_q;
   reg ctrl_dir_q;
   reg [7:0] rd_data_q;
   reg recog_q;
   reg ecc_fix_q;
   reg ecc_bad_q;
   reg sh_we;
   reg [2:0] sh_idx;
   reg [15:0] sh_val;
   wire [15:0] fuse_fixed;
   wire fuse_corrected;
   wire fuse_bad;
   integer k;

   // Shadow window index from a byte address
   function [2:0] cel_word_index;
      input [11:0] addr;
      begin
         cel_word_index = addr[4:2];
      end
   endfunction

   // Address inside the shadow window
   function cel_in_shadow;
      input [11:0] addr;
      begin
         cel_in_shadow = (addr >= `CEL_SHADOW_BASE) && (addr <= `CEL_SHADOW_LAST)
            && (addr[1:0] == 2'b00);
      end
   endfunction

   // APB decode; the slave never inserts wait states
   wire apb_setup = psel & ~penable;
   wire apb_access = psel & penable;
   wire hit_ctrl = (paddr == `CEL_CTRL_OFF);
   wire hit_stat = (paddr == `CEL_STAT_OFF);
   wire hit_shadow = cel_in_shadow(paddr);
   wire apb_wr = apb_access & pwrite;
   wire busy = ~state_q[3];
   assign pready = 1'b1;

   // Read data and error are registered in the setup cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (apb_setup)
      begin
         pslverr <= ~(hit_ctrl | hit_stat | hit_shadow);
         if (pwrite)
            prdata <= 32'h00000000;
         else if (hit_ctrl)
            prdata <= {rd_data_q, 7'h00, ctrl_dir_q, nvm_write_byte_field_q,
               ctrl_addr_q};
         else if (hit_stat)
            prdata <= {27'h0000000, ecc_bad_q, ecc_fix_q, recog_q, busy, cal_valid_q};
         else if (hit_shadow)
            prdata <= {16'h0000, shadow_q[cel_word_index(paddr)]};
         else
            prdata <= 32'h00000000;
      end
   end

   // Control register: taken only while the loader is idle
   wire ctrl_take = apb_wr & hit_ctrl & state_q[3];
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_addr_q <= `CEL_CTRL_RESET;
         nvm_write_byte_field_q <= `CEL_RDATA_RESET;
         ctrl_dir_q <= `CEL_DIR_WRITE;
      end
      else if (ctrl_take)
      begin
         if (pstrb[0])
            ctrl_addr_q <= pwdata[`CEL_CTRL_ADDR_LSB+7:`CEL_CTRL_ADDR_LSB];
         if (pstrb[1])
            nvm_write_byte_field_q <= pwdata[`CEL_CTRL_WBYTE_LSB+7:`CEL_CTRL_WBYTE_LSB];
         if (pstrb[2])
            ctrl_dir_q <= pwdata[`CEL_CTRL_DIR_BIT];
      end
   end

   // ECC on the fuse path
   assign fuse_addr = word_q;
   cel_ecc u_ecc
   (
      .raw_data(fuse_data),
      .raw_check(fuse_check),
      .fixed_data(fuse_fixed),
      .corrected(fuse_corrected),
      .uncorrectable(fuse_bad)
   );

   // Next state of the loader
   wire load_last = (byte_q == `CEL_LAST_BYTE);
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_FUSE:
            if (word_q == `CEL_LAST_WORD)
               state_d = ST_KEY;
         ST_KEY:
            if (!nvm_present)
               state_d = ST_IDLE;
            else if (nvm_req_q && nvm_ack)
               state_d = (nvm_rdata == `CEL_KEY_VALUE) ? ST_LOAD : ST_IDLE;
         ST_LOAD:
            if (nvm_req_q && nvm_ack && load_last)
               state_d = ST_IDLE;
         ST_IDLE:
            if (ctrl_take && pstrb[2])
               state_d = ST_CMD;
         ST_CMD:
            if (nvm_req_q && nvm_ack)
               state_d = ST_IDLE;
         default:
            state_d = ST_FUSE;
      endcase
   end

   // Loader sequencing and EEPROM requests
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_FUSE;
         word_q <= 3'h0;
         byte_q <= 5'h01;
         hi_byte_q <= 8'h00;
         nvm_req_q <= 1'b0;
         nvm_we_q <= 1'b0;
         nvm_addr_q <= 8'h00;
         nvm_wdata_q <= 8'h00;
         rd_data_q <= `CEL_RDATA_RESET;
         recog_q <= 1'b0;
         cal_valid_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         case (state_q)
            ST_FUSE:
               word_q <= word_q + 3'h1;
            ST_KEY:
               if (!nvm_present)
                  nvm_req_q <= 1'b0;
               else if (!nvm_req_q)
               begin
                  nvm_req_q <= 1'b1;
                  nvm_we_q <= 1'b0;
                  nvm_addr_q <= `CEL_KEY_ADDR;
               end
               else if (nvm_ack)
               begin
                  nvm_req_q <= 1'b0;
                  recog_q <= (nvm_rdata == `CEL_KEY_VALUE);
               end
            ST_LOAD:
               if (!nvm_req_q)
               begin
                  nvm_req_q <= 1'b1;
                  nvm_we_q <= 1'b0;
                  nvm_addr_q <= {3'b000, byte_q};
               end
               else if (nvm_ack)
               begin
                  nvm_req_q <= 1'b0;
                  byte_q <= byte_q + 5'h01;
                  if (byte_q[0])
                     hi_byte_q <= nvm_rdata;
               end
            ST_IDLE:
            begin
               cal_valid_q <= 1'b1;
               if (ctrl_take && pstrb[2])
               begin
                  nvm_req_q <= 1'b1;
                  nvm_we_q <= ~pwdata[`CEL_CTRL_DIR_BIT];
                  nvm_addr_q <= pstrb[0] ? pwdata[7:0] : ctrl_addr_q;
                  nvm_wdata_q <= pstrb[1] ? pwdata[15:8] : nvm_write_byte_field_q;
               end
            end
            ST_CMD:
               if (nvm_ack)
               begin
                  nvm_req_q <= 1'b0;
                  nvm_we_q <= 1'b0;
                  if (!nvm_we_q)
                     rd_data_q <= nvm_rdata;
               end
            default:
               nvm_req_q <= 1'b0;
         endcase
      end
   end

   // One write source for the shadow memory at a time
   always @*
   begin
      sh_we = 1'b0;
      sh_idx = 3'h0;
      sh_val = `CEL_WORD_RESET;
      if (state_q[0])
      begin
         sh_we = 1'b1;
         sh_idx = word_q;
         sh_val = fuse_fixed;
      end
      else if (state_q[2] && nvm_req_q && nvm_ack && !byte_q[0])
      begin
         sh_we = 1'b1;
         sh_idx = byte_q[3:1] - 3'h1;
         sh_val = {hi_byte_q, nvm_rdata};
      end
      else if (apb_wr && hit_shadow && !busy)
      begin
         sh_we = 1'b1;
         sh_idx = cel_word_index(paddr);
         sh_val = shadow_q[cel_word_index(paddr)];
         if (pstrb[0])
            sh_val[7:0] = pwdata[7:0];
         if (pstrb[1])
            sh_val[15:8] = pwdata[15:8];
      end
   end

   // Shadow memory words
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (k = 0; k < `CEL_WORDS; k = k + 1)
            shadow_q[k] <= `CEL_WORD_RESET;
      end
      else if (sh_we)
         shadow_q[sh_idx] <= sh_val;
   end

   // Sticky ECC flags; a fresh event beats a write-one clear
   wire stat_clr = apb_wr & hit_stat & pstrb[0];
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ecc_fix_q <= 1'b0;
         ecc_bad_q <= 1'b0;
      end
      else
      begin
         if (state_q[0] && fuse_corrected)
            ecc_fix_q <= 1'b1;
         else if (stat_clr && pwdata[`CEL_STAT_ECC_FIX_BIT])
            ecc_fix_q <= 1'b0;
         if (state_q[0] && fuse_bad)
            ecc_bad_q <= 1'b1;
         else if (stat_clr && pwdata[`CEL_STAT_ECC_BAD_BIT])
            ecc_bad_q <= 1'b0;
      end
   end

   // Field layout of the shadow words
   assign odd_cell_room_gain_delta = shadow_q[0][9:0];
   assign first_pair_room_delta = shadow_q[0][13:10];
   assign odd_cell_cold_gain_delta = shadow_q[1][6:0];
   assign odd_cell_hot_gain_delta = shadow_q[1][13:7];
   wire [7:0] diag_reference_gain_delta = shadow_q[2][7:0];
   wire [9:0] third_room = shadow_q[3][9:0];
   assign second_pair_room_delta = shadow_q[3][11:10];
   wire [6:0] third_cold = {shadow_q[4][5], shadow_q[4][5:0]};
   wire [6:0] third_hot = {shadow_q[4][11], shadow_q[4][11:6]};

   // Temperature-compensated gains of cells one and three
   cel_gain u_gain_first
   (
      .pclk(pclk),
      .presetn(presetn),
      .room_delta(odd_cell_room_gain_delta),
      .cold_delta(odd_cell_cold_gain_delta),
      .hot_delta(odd_cell_hot_gain_delta),
      .die_temp(die_temp),
      .gain_q(first_cell_gain)
   );

   cel_gain u_gain_third
   (
      .pclk(pclk),
      .presetn(presetn),
      .room_delta(third_room),
      .cold_delta(third_cold),
      .hot_delta(third_hot),
      .die_temp(die_temp),
      .gain_q(third_cell_gain)
   );

   // Diagnostic reference: double step, added to the first cell gain
   wire [15:0] diag_ext = {{7{diag_reference_gain_delta[7]}}, diag_reference_gain_delta, 1'b0};
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         diag_reference_gain_q <= `CEL_WORD_RESET;
      else
         diag_reference_gain_q <= first_cell_gain + diag_ext;
   end

endmodule // cel_loader

// ==== hdl/cel_regs.vh ====
// Purpose: Constants for the calibration loader: offsets, fields, resets, geometry, temperatures
// Assumes: APB byte addresses, 32-bit data, one aligned word per register
// Notes: Definitions only
`ifndef CEL_REGS_VH
`define CEL_REGS_VH

// Register byte offsets
`define CEL_CTRL_OFF 12'h000
`define CEL_STAT_OFF 12'h004
`define CEL_SHADOW_BASE 12'h040
`define CEL_SHADOW_LAST 12'h05C

// Control register fields
`define CEL_CTRL_ADDR_LSB 0
`define CEL_CTRL_WBYTE_LSB 8
`define CEL_CTRL_DIR_BIT 16
`define CEL_CTRL_RDATA_LSB 24
`define CEL_DIR_WRITE 1'b0
`define CEL_DIR_READ 1'b1

// Status register fields
`define CEL_STAT_DONE_BIT 0
`define CEL_STAT_BUSY_BIT 1
`define CEL_STAT_RECOG_BIT 2
`define CEL_STAT_ECC_FIX_BIT 3
`define CEL_STAT_ECC_BAD_BIT 4

// Reset values
`define CEL_CTRL_RESET 8'h00
`define CEL_RDATA_RESET 8'h00
`define CEL_WORD_RESET 16'h0000

// Shadow memory and nonvolatile store geometry
`define CEL_WORDS 8
`define CEL_LAST_WORD 3'h7
`define CEL_LAST_BYTE 5'h10
`define CEL_KEY_ADDR 8'h00
`define CEL_KEY_VALUE 8'hCB

// Die temperatures for the gain model, degrees C, then its cold scale and shift amounts
`define CEL_T_COLD (-8'sd40)
`define CEL_T_ROOM 9'sd25
`define CEL_T_HOT 8'sd89
`define CEL_COLD_SCALE 8'sd63
`define CEL_COLD_SHIFT 12
`define CEL_HOT_SHIFT 6

`endif

// ==== hdl/cel_ecc.v ====
// Purpose: Single-error-correcting check on one 16-bit calibration word
// Assumes: Five check bits, each data bit owns a distinct code of weight two or more
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
module cel_ecc
(
   // Stored word
   input wire [15:0] raw_data,
   input wire [4:0] raw_check,
   // Checked word
   output reg [15:0] fixed_data,
   output reg corrected,
   output reg uncorrectable
);

   // Syndrome code owned by each data bit
   function [4:0] cel_bit_code;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: cel_bit_code = 5'h03;
            4'h1: cel_bit_code = 5'h05;
            4'h2: cel_bit_code = 5'h06;
            4'h3: cel_bit_code = 5'h07;
            4'h4: cel_bit_code = 5'h09;
            4'h5: cel_bit_code = 5'h0A;
            4'h6: cel_bit_code = 5'h0B;
            4'h7: cel_bit_code = 5'h0C;
            4'h8: cel_bit_code = 5'h0D;
            4'h9: cel_bit_code = 5'h0E;
            4'hA: cel_bit_code = 5'h0F;
            4'hB: cel_bit_code = 5'h11;
            4'hC: cel_bit_code = 5'h12;
            4'hD: cel_bit_code = 5'h13;
            4'hE: cel_bit_code = 5'h14;
            default: cel_bit_code = 5'h15;
         endcase
      end
   endfunction

   // Syndrome, then flip the single bit it names
   reg [4:0] syndrome;
   reg hit;
   integer i;
   always @*
   begin
      syndrome = raw_check;
      hit = 1'b0;
      fixed_data = raw_data;
      for (i = 0; i < 16; i = i + 1)
         if (raw_data[i])
            syndrome = syndrome ^ cel_bit_code(i[3:0]);
      for (i = 0; i < 16; i = i + 1)
         if (syndrome == cel_bit_code(i[3:0]))
         begin
            fixed_data[i] = ~raw_data[i];
            hit = 1'b1;
         end
      corrected = hit | (syndrome != 5'h00 && (syndrome & (syndrome - 5'h01)) == 5'h00);
      uncorrectable = (syndrome != 5'h00) & ~corrected;
   end

endmodule // cel_ecc

// ==== hdl/cel_gain.v ====
// Purpose: Temperature-compensated gain delta of one odd cell
// Assumes: Die temperature in signed degrees C; deltas in 0.01221 % steps
// Notes: Cold span 65 C approximated by 63/4096, hot span 64 C is a shift
`timescale 1ns/1ps
`include "cel_regs.vh"
module cel_gain
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Scalars from shadow memory and die temperature
   input wire [9:0] room_delta,
   input wire [6:0] cold_delta,
   input wire [6:0] hot_delta,
   input wire [7:0] die_temp,
   // Gain delta at present temperature
   output reg [15:0] gain_q
);

   // Clamp temperature to the characterised span
   reg signed [7:0] temp_c;
   always @*
   begin
      if ($signed(die_temp) < `CEL_T_COLD)
         temp_c = `CEL_T_COLD;
      else if ($signed(die_temp) > `CEL_T_HOT)
         temp_c = `CEL_T_HOT;
      else
         temp_c = $signed(die_temp);
   end

   // Interpolate between room and cold or hot scalars
   wire signed [8:0] below_room = `CEL_T_ROOM - temp_c;
   wire signed [8:0] above_room = temp_c - `CEL_T_ROOM;
   wire signed [24:0] cold_prod = $signed(cold_delta) * below_room * `CEL_COLD_SCALE;
   wire signed [16:0] hot_prod = $signed(hot_delta) * above_room;
   wire [15:0] cold_part = {{3{cold_prod[24]}}, cold_prod[24:`CEL_COLD_SHIFT]};
   wire [15:0] hot_part = {{5{hot_prod[16]}}, hot_prod[16:`CEL_HOT_SHIFT]};
   wire [15:0] room_ext = {{6{room_delta[9]}}, room_delta};
   wire [15:0] gain_d = room_ext + (below_room > 9'sd0 ? cold_part : hot_part);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gain_q <= `CEL_WORD_RESET;
      else
         gain_q <= gain_d;
   end

endmodule // cel_gain

// ==== testbench/cel_loader_sva.sv ====
// Purpose: Concurrent checks on the calibration loader ports
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every loader instance
`timescale 1ns/1ps
`include "cel_regs.vh"
module cel_loader_sva
(
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // Bus request
   input logic [11:0] paddr,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [31:0] pwdata,
   input logic [3:0] pstrb,
   // Loader state
   input logic cal_valid_q,
   input logic [2:0] fuse_addr,
   // EEPROM port
   input logic nvm_req_q,
   input logic nvm_we_q,
   input logic [7:0] nvm_addr_q,
   input logic [7:0] nvm_wdata_q,
   input logic nvm_ack,
   input logic [7:0] nvm_rdata,
   // Gain path
   input logic [7:0] die_temp,
   input logic [15:0] first_cell_gain,
   input logic [9:0] odd_cell_room_gain_delta,
   input logic [6:0] odd_cell_hot_gain_delta
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Control write with start lane while the port is quiet
   sequence s_cmd;
      psel && penable && pwrite && paddr == `CEL_CTRL_OFF && &pstrb[2:0] && cal_valid_q
         && !nvm_req_q && !$past(nvm_req_q);
   endsequence
   // Read answered during the load
   sequence s_load_ack;
      nvm_req_q && nvm_ack && !nvm_we_q && !cal_valid_q;
   endsequence
   // Gain inputs held still at one temperature
   sequence s_calm(t);
      (cal_valid_q && die_temp == t && $stable(odd_cell_room_gain_delta)
         && $stable(odd_cell_hot_gain_delta)) [*4];
   endsequence
   property p_req_hold;
      nvm_req_q && !nvm_ack |=> nvm_req_q && $stable(nvm_we_q) && $stable(nvm_addr_q)
         && $stable(nvm_wdata_q);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("request changed before acknowledge");
   property p_sw_wr;
      s_cmd ##0 !pwdata[`CEL_CTRL_DIR_BIT] |=> nvm_req_q && nvm_we_q
         && nvm_addr_q == $past(pwdata[7:0]) && nvm_wdata_q == $past(pwdata[15:8]);
   endproperty
   a_sw_wr: assert property (p_sw_wr)
      else $error("write command not issued");
   property p_sw_rd;
      s_cmd ##0 pwdata[`CEL_CTRL_DIR_BIT] |=> nvm_req_q && !nvm_we_q
         && nvm_addr_q == $past(pwdata[7:0]);
   endproperty
   a_sw_rd: assert property (p_sw_rd)
      else $error("read command not issued");
   property p_key_bad;
      s_load_ack ##0 nvm_addr_q == `CEL_KEY_ADDR && nvm_rdata != `CEL_KEY_VALUE
         |=> !nvm_req_q [*2];
   endproperty
   a_key_bad: assert property (p_key_bad)
      else $error("wrong key not ignored");
   property p_key_ok;
      s_load_ack ##0 nvm_addr_q == `CEL_KEY_ADDR && nvm_rdata == `CEL_KEY_VALUE
         |=> !nvm_req_q ##1 nvm_req_q && !nvm_we_q && nvm_addr_q == 8'h01;
   endproperty
   a_key_ok: assert property (p_key_ok)
      else $error("reload not started after key");
   property p_load_next;
      s_load_ack ##0 nvm_addr_q != 8'h00 && nvm_addr_q < `CEL_LAST_BYTE
         |=> !nvm_req_q ##1 nvm_req_q && nvm_addr_q == $past(nvm_addr_q, 2) + 8'h01;
   endproperty
   a_load_next: assert property (p_load_next)
      else $error("reload byte order broken");
   property p_fuse_walk;
      !cal_valid_q && fuse_addr != 3'h0 && fuse_addr != 3'h7
         |=> fuse_addr == $past(fuse_addr) + 3'h1;
   endproperty
   a_fuse_walk: assert property (p_fuse_walk)
      else $error("fuse walk skipped a word");
   property p_gain_room;
      s_calm(8'd25) |-> first_cell_gain ==
         {{6{odd_cell_room_gain_delta[9]}}, odd_cell_room_gain_delta};
   endproperty
   a_gain_room: assert property (p_gain_room)
      else $error("room gain wrong");
   property p_gain_hot;
      s_calm(8'd89) |-> first_cell_gain ==
         {{6{odd_cell_room_gain_delta[9]}}, odd_cell_room_gain_delta}
         + {{9{odd_cell_hot_gain_delta[6]}}, odd_cell_hot_gain_delta};
   endproperty
   a_gain_hot: assert property (p_gain_hot)
      else $error("hot gain wrong");
endmodule // cel_loader_sva

bind cel_loader cel_loader_sva u_sva (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
   .pwdata, .pstrb, .cal_valid_q, .fuse_addr, .nvm_req_q, .nvm_we_q, .nvm_addr_q,
   .nvm_wdata_q, .nvm_ack, .nvm_rdata, .die_temp, .first_cell_gain,
   .odd_cell_room_gain_delta, .odd_cell_hot_gain_delta);

// ==== testbench/cel_nvm_model.sv ====
// Purpose: Behavioural byte EEPROM on the request/acknowledge port
// Assumes: Answer after no wait or three idle cycles
// Notes: Outside the answer cycle the read byte is the inverse of the last one
`timescale 1ns/1ps
module cel_nvm_model
(
   // Clock and pace
   input logic pclk,
   input logic slow,
   // Request side
   input logic nvm_req_q,
   input logic nvm_we_q,
   input logic [7:0] nvm_addr_q,
   input logic [7:0] nvm_wdata_q,
   // Answer side
   output logic nvm_ack,
   output logic [7:0] nvm_rdata
);
   logic [7:0] mem [256];
   logic [7:0] last_q = 8'h00;
   logic done_q = 1'b0;
   int wait_q = 0;
   initial nvm_ack = 1'b0;
   initial nvm_rdata = 8'h00;
   // One acknowledge per request; a new one only after the request drops
   always @(posedge pclk)
   begin
      nvm_ack <= 1'b0;
      nvm_rdata <= ~last_q;
      if (!nvm_req_q)
      begin
         done_q <= 1'b0;
         wait_q <= 0;
      end
      else if (!done_q && !nvm_ack)
      begin
         if (wait_q < (slow ? 3 : 0))
            wait_q <= wait_q + 1;
         else
         begin
            nvm_ack <= 1'b1;
            done_q <= 1'b1;
            nvm_rdata <= mem[nvm_addr_q];
            last_q <= mem[nvm_addr_q];
            if (nvm_we_q)
               mem[nvm_addr_q] <= nvm_wdata_q;
         end
      end
   end
endmodule // cel_nvm_model

// ==== testbench/cel_loader_bench.sv ====
// Purpose: Self-checking bench for the calibration loader
// Assumes: Zero-wait APB slave, fuse array modelled here
// Notes: Read expectations are queued by the driver and checked by a monitor
`timescale 1ns/1ps
`include "cel_regs.vh"
module cel_loader_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nvm_present, slow;
   logic nvm_req_q, nvm_we_q, nvm_ack, cal_valid_q;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   logic [2:0] fuse_addr;
   logic [15:0] fuse_data, first_cell_gain, third_cell_gain, diag_reference_gain_q, g;
   logic [4:0] fuse_check;
   logic [7:0] nvm_addr_q, nvm_wdata_q, nvm_rdata, die_temp;
   logic [9:0] odd_cell_room_gain_delta;
   logic [3:0] first_pair_room_delta;
   logic [1:0] second_pair_room_delta;
   logic [6:0] odd_cell_cold_gain_delta, odd_cell_hot_gain_delta;
   logic [15:0] fuse_mem [8];
   logic [4:0] fuse_chk [8];
   logic [15:0] w [8];
   logic [7:0] nb [17];
   logic [32:0] expq [$];
   logic [32:0] maskq [$];
   logic [32:0] e, m;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   assign fuse_data = fuse_mem[fuse_addr];
   assign fuse_check = fuse_chk[fuse_addr];
   cel_loader DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
      .pready, .prdata, .pslverr, .fuse_addr, .fuse_data, .fuse_check, .nvm_present,
      .nvm_req_q, .nvm_we_q, .nvm_addr_q, .nvm_wdata_q, .nvm_ack, .nvm_rdata, .die_temp,
      .cal_valid_q, .first_cell_gain, .third_cell_gain, .odd_cell_room_gain_delta,
      .first_pair_room_delta, .second_pair_room_delta, .odd_cell_cold_gain_delta,
      .odd_cell_hot_gain_delta, .diag_reference_gain_q);
   cel_nvm_model eep (.pclk, .slow, .nvm_req_q, .nvm_we_q, .nvm_addr_q, .nvm_wdata_q,
      .nvm_ack, .nvm_rdata);
   always #5 pclk = ~pclk;
   // Check codes: weight-two-or-more codes in rising order
   function automatic logic [4:0] ecc5(input logic [15:0] d);
      logic [4:0] c = 5'h00;
      logic [5:0] v = 6'h02;
      for (int i = 0; i < 16; i++)
      begin
         v++;
         if (v == 6'h04 || v == 6'h08 || v == 6'h10)
            v++;
         if (d[i])
            c ^= v[4:0];
      end
      return c;
   endfunction
   function automatic logic [15:0] sx(input logic [15:0] v, input int b);
      return 16'($signed(v << (16 - b)) >>> (16 - b));
   endfunction
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task finish_test;
      if (mismatches == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One APB transfer; reads leave their expectation in the queue
   task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d,
      input logic [32:0] ex, input logic [32:0] mk);
      if (!wr)
      begin
         expq.push_back(ex);
         maskq.push_back(mk);
      end
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_idle;
      do
         apb(`CEL_STAT_OFF, 1'b0, 32'h0, 33'h0, 33'h0);
      while (q[`CEL_STAT_BUSY_BIT] !== 1'b0 || q[`CEL_STAT_DONE_BIT] !== 1'b1);
   endtask
   // Monitor: pops the oldest note for each completed read and compares when its mask is nonzero
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite && expq.size() > 0)
      begin
         e = expq.pop_front();
         m = maskq.pop_front();
         if (m != 33'h0)
            chk({pslverr, prdata} & m, e & m);
      end
   // Hang guard
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         finish_test;
      end
   end
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, slow} = 6'h00;
      {paddr, pwdata, pstrb, die_temp, nvm_present} = {12'h000, 32'h0, 4'hF, 8'd25, 1'b1};
      void'($urandom(38302));
      // Fuse words match their check codes except word 2, which carries a single flipped bit
      for (int i = 0; i < 8; i++)
      begin
         w[i] = 16'($urandom);
         fuse_chk[i] = ecc5(w[i]);
         fuse_mem[i] = w[i] ^ ((i == 2) ? 16'h0020 : 16'h0000);
      end
      for (int i = 0; i < 256; i++)
         eep.mem[i] = 8'(i) ^ 8'hA5; // Byte 0 is not the key
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      wait_idle;
      apb(`CEL_STAT_OFF, 1'b0, 32'h0, 33'h09, 33'h1F);
      for (int i = 0; i < 8; i++)
         apb(`CEL_SHADOW_BASE + 12'(4 * i), 1'b0, 32'h0, {17'h0, w[i]}, 33'h0FFFF);
      apb(12'h100, 1'b0, 32'h0, 33'h100000000, 33'h1FFFFFFFF);
      // Key then a full gain copy into the leading bytes
      for (int a = 0; a <= 16; a++)
      begin
         nb[a] = (a == 0) ? `CEL_KEY_VALUE : 8'($urandom);
         slow <= a[0];
         apb(`CEL_CTRL_OFF, 1'b1, {15'h0, `CEL_DIR_WRITE, nb[a], 8'(a)}, 33'h0, 33'h0);
         wait_idle;
      end
      for (int a = 0; a <= 16; a++)
      begin
         apb(`CEL_CTRL_OFF, 1'b1, {15'h0, `CEL_DIR_READ, 8'h00, 8'(a)}, 33'h0, 33'h0);
         wait_idle;
         apb(`CEL_CTRL_OFF, 1'b0, 32'h0, {1'b0, nb[a], 7'h0, 1'b1, 16'(a)}, 33'h0FF0100FF);
      end
      // Second reset in mid-run: the keyed EEPROM now replaces the fuse image
      slow <= 1'b1;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      wait_idle;
      apb(`CEL_STAT_OFF, 1'b0, 32'h0, 33'h05, 33'h07);
      for (int i = 0; i < 8; i++)
      begin
         w[i] = {nb[2 * i + 1], nb[2 * i + 2]};
         apb(`CEL_SHADOW_BASE + 12'(4 * i), 1'b0, 32'h0, {17'h0, w[i]}, 33'h0FFFF);
      end
      w[2] = 16'($urandom);
      apb(`CEL_SHADOW_BASE + 12'h008, 1'b1, {16'h0, w[2]}, 33'h0, 33'h0);
      apb(`CEL_SHADOW_BASE + 12'h008, 1'b0, 32'h0, {17'h0, w[2]}, 33'h0FFFF);
      // Gain outputs at room, hot and cold die temperature
      repeat (6) @(posedge pclk);
      g = sx(w[0], 10);
      chk({first_pair_room_delta, second_pair_room_delta, odd_cell_cold_gain_delta,
         odd_cell_hot_gain_delta, odd_cell_room_gain_delta, 3'h0}, {w[0][13:10], w[3][11:10],
         w[1][6:0], w[1][13:7], w[0][9:0], 3'h0});
      chk({17'h0, first_cell_gain}, {17'h0, g});
      chk({17'h0, diag_reference_gain_q}, {17'h0, 16'(g + {sx(w[2], 8), 1'b0})});
      die_temp <= 8'd89;
      repeat (6) @(posedge pclk);
      chk({17'h0, first_cell_gain}, {17'h0, g + sx(w[1] >> 7, 7)});
      chk({17'h0, third_cell_gain}, {17'h0, sx(w[3], 10) + sx(w[4] >> 6, 6)});
      die_temp <= 8'hD8;
      repeat (6) @(posedge pclk);
      g = 16'((int'($signed(sx(w[4], 6))) * 4095) >>> 12);
      chk({17'h0, third_cell_gain}, {17'h0, sx(w[3], 10) + g});
      nvm_present <= 1'b0;
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      wait_idle;
      apb(`CEL_STAT_OFF, 1'b0, 32'h0, 33'h09, 33'h1F);
      finish_test;
   end
endmodule // cel_loader_bench
